// File: tb/cpu_seq_model.sv
// instruction sequencer model: boundary strobes, long string ops and a program counter.
// assumes ref_clk and rstn of the block; longOp is a level from the bench.
`timescale 1ns/100ps
module cpu_seq_model
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        longOp,
    output      logic        instrDone,
    output      logic        interruptibleOp,
    output      logic [19:0] pcValue
);
    logic [1:0] phase;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase           <= 2'h0;
            instrDone       <= 1'b0;
            interruptibleOp <= 1'b0;
            pcValue         <= 20'h01000;
        end
        else
        begin
            phase           <= phase + 2'h1;
            // a string op never reaches its boundary, so only suspension can enter
            instrDone       <= !longOp && phase == 2'h3;
            interruptibleOp <= longOp;
            pcValue         <= pcValue + {19'h0, phase == 2'h3};
        end
    end
endmodule

// File: tb/irq_accept_props.sv
// concurrent checks on the ports of the interrupt acceptance block.
// assumes one ref_clk domain; entry timing is counted from the info fetch pulse.
`timescale 1ns/100ps
module irq_accept_props
    import irq_accept_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        instrDone,
    input wire logic        interruptibleOp,
    input wire logic        swIntReq,
    input wire info_fetch_t infoFetch,
    input wire stack_push_t stackPush,
    input wire logic        vectorFetch,
    input wire logic        suspendOp,
    input wire logic        seqBusy,
    input wire logic [15:0] processorFlagWord
);
    logic [2:0] iplNow;
    logic       enNow;
    logic       swTake;
    logic       boundary;
    assign iplNow   = processorFlagWord[FLG_IPL_LSB +: LEVEL_W];
    assign enNow    = processorFlagWord[FLG_I_BIT];
    assign swTake   = swIntReq && instrDone;
    assign boundary = instrDone || interruptibleOp;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_fetch_addr_zero: assert property (infoFetch.readStrobe |-> infoFetch.addr == INFO_ADDR && seqBusy)
        else $error("info fetch not at address zero");
    a_push_order: assert property (infoFetch.readStrobe |-> ##3 (stackPush.valid && !stackPush.isPc) ##1 (stackPush.valid && stackPush.isPc))
        else $error("stack pushes out of order");
    a_vector_after: assert property (infoFetch.readStrobe |-> ##6 vectorFetch)
        else $error("vector fetch late or missing");
    a_enable_cleared: assert property (stackPush.valid && !stackPush.isPc |-> !enNow && !processorFlagWord[FLG_D_BIT])
        else $error("enable or debug flag not cleared");
    a_accept_enabled: assert property ($rose(seqBusy) && !$past(swTake) |-> $past(enNow))
        else $error("accepted with global enable low");
    a_threshold_gate: assert property ($rose(seqBusy) && !$past(swTake) |-> $past(iplNow) != 3'h7)
        else $error("accepted with threshold seven");
    a_suspend_op: assert property (suspendOp |-> infoFetch.readStrobe && $past(interruptibleOp) && !$past(instrDone))
        else $error("suspend without interruptible op");
    a_entry_boundary: assert property (infoFetch.readStrobe |-> $past(boundary))
        else $error("entry not at instruction boundary");
    a_no_reentry: assert property (seqBusy && !vectorFetch |=> !infoFetch.readStrobe)
        else $error("new entry while sequence busy");
endmodule
bind maskable_interrupt_acceptance irq_accept_props props (.ref_clk(ref_clk), .rstn(rstn), .instrDone(instrDone),
    .interruptibleOp(interruptibleOp), .swIntReq(swIntReq), .infoFetch(infoFetch), .stackPush(stackPush),
    .vectorFetch(vectorFetch), .suspendOp(suspendOp), .seqBusy(seqBusy), .processorFlagWord(processorFlagWord));

// File: tb/maskable_interrupt_acceptance_bench.sv
// self-checking bench for the interrupt acceptance block.
// assumes the sequencer model drives the boundary strobes; software interrupts are driven only by t_soft_entry.
`timescale 1ns/100ps
module maskable_interrupt_acceptance_bench;
    import irq_accept_pkg::*;
    logic ref_clk = 0, rstn = 0, regWrite = 0, regRead = 0, longOp = 0, instrDone, interruptibleOp, vectorFetch;
    logic suspendOp, seqBusy, seen, susp, swIntReq = 0;
    logic [5:0] swIntNum = 0;
    logic [19:0] pushedFlg;
    logic [7:0] regAddr = 0;
    logic [15:0] regWdata = 0, regRdata, processorFlagWord, rd;
    logic [28:0] reqPulse = 0;
    logic [19:0] pcValue;
    logic [5:0] vectorNum;
    info_fetch_t infoFetch;
    stack_push_t stackPush;
    int errors = 0, num_checks = 0, cycles = 0;
    cpu_seq_model seq (.ref_clk(ref_clk), .rstn(rstn), .longOp(longOp), .instrDone(instrDone),
        .interruptibleOp(interruptibleOp), .pcValue(pcValue));
    maskable_interrupt_acceptance DUT (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .reqPulse(reqPulse), .instrDone(instrDone),
        .interruptibleOp(interruptibleOp), .swIntReq(swIntReq), .swIntNum(swIntNum), .pcValue(pcValue),
        .infoFetch(infoFetch), .stackPush(stackPush), .vectorFetch(vectorFetch), .vectorNum(vectorNum),
        .suspendOp(suspendOp), .seqBusy(seqBusy), .processorFlagWord(processorFlagWord));
    initial forever #12.5 ref_clk = ~ref_clk;
    task wrap_up;
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            wrap_up;
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // the pulse rides with the strobe so a same-cycle set and clear can be made
    task wr(input logic [7:0] a, input logic [15:0] d, input logic [28:0] p);
        @(posedge ref_clk);
        regWrite <= 1; regAddr <= a; regWdata <= d; reqPulse <= p;
        @(posedge ref_clk);
        regWrite <= 0; reqPulse <= 0;
    endtask
    task rdchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regRead <= 1; regAddr <= a;
        @(posedge ref_clk);
        regRead <= 0;
        #1 chk(regRdata, exp);
    endtask
    task waitVec;
        seen = 0;
        susp = 0;
        pushedFlg = 0;
        repeat (14)
        begin
            @(posedge ref_clk);
            #1 if (vectorFetch === 1'b1) seen = 1;
            if (suspendOp === 1'b1) susp = 1;
            if (stackPush.valid === 1'b1 && stackPush.isPc === 1'b0) pushedFlg = stackPush.data;
        end
    endtask
    // software entry: request held until the sequence is seen busy, then dropped
    task t_soft_entry(input logic [5:0] num, input logic [15:0] expFlg);
        wr(8'h00, 16'h0084, 29'h0);
        @(posedge ref_clk);
        swIntReq <= 1; swIntNum <= num;
        do
        begin
            @(posedge ref_clk);
            #1;
        end
        while (seqBusy !== 1'b1);
        @(posedge ref_clk);
        swIntReq <= 0;
        waitVec;
        chk(16'(seen), 16'h0001);
        chk(16'(vectorNum), 16'(num));
        chk(pushedFlg[15:0], 16'h0084);
        rdchk(8'h00, expFlg);
    endtask
    task t_reset_and_pending;
        rdchk(8'h00, 16'h0000);
        rdchk(8'h44, 16'h0000);
        wr(8'h20, 16'hffff, 29'h10);
        rdchk(8'h20, 16'h0000);
        rdchk(8'h44, 16'h0008);
        rdchk(8'h00, 16'h0000);
        wr(8'h44, 16'h000a, 29'h0);
        rdchk(8'h44, 16'h000a);
        wr(8'h43, 16'h0001, 29'h8);
        rdchk(8'h43, 16'h0009);
        wr(8'h43, 16'h0000, 29'h0);
        wr(8'h44, 16'h0000, 29'h0);
        rdchk(8'h44, 16'h0000);
    endtask
    task t_threshold;
        for (int n = 0; n < 8; n++)
        begin
            wr(8'h00, 16'h0000, 29'h0);
            wr(8'h41, 16'h0003, 29'h2);
            repeat (2) @(posedge ref_clk);
            wr(8'h00, 16'h0040 | (16'(n) << 12), 29'h0);
            waitVec;
            chk(16'(seen), 16'(n < 3));
            if (n < 3)
            begin
                chk(16'(vectorNum), 16'h0004);
                chk(pushedFlg[15:0], 16'h0040 | (16'(n) << 12));
                chk(16'(susp), 16'h0000);
                rdchk(8'h00, 16'h3000);
                rdchk(8'h41, 16'h0003);
            end
        end
        wr(8'h00, 16'h0000, 29'h0);
        wr(8'h41, 16'h0000, 29'h0);
    endtask
    task t_tie_and_suspend;
        wr(8'h42, 16'h0004, 29'h4);
        wr(8'h45, 16'h0004, 29'h20);
        wr(8'h00, 16'h0040, 29'h0);
        waitVec;
        chk(16'(vectorNum), 16'h0005);
        rdchk(8'h45, 16'h000c);
        wr(8'h00, 16'h0000, 29'h0);
        wr(8'h45, 16'h0000, 29'h0);
        longOp <= 1;
        wr(8'h40, 16'h0001, 29'h1);
        wr(8'h00, 16'h0040, 29'h0);
        waitVec;
        chk(16'(seen), 16'h0001);
        chk(16'(susp), 16'h0001);
        chk(16'(vectorNum), 16'h0003);
        longOp <= 0;
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1;
        t_reset_and_pending;
        t_threshold;
        t_tie_and_suspend;
        t_soft_entry(6'h20, 16'h0080);
        t_soft_entry(6'h10, 16'h0000);
        wrap_up;
    end
endmodule

// File: verilog/irq_accept_pkg.sv
// constants, state codes and carrier types of the maskable interrupt acceptance block.
// assumes a single 40 MHz cpu clock and one register port in the same domain.
package irq_accept_pkg;

    // register port
    localparam int          REG_ADDR_W        = 8;
    localparam int          REG_DATA_W        = 16;
    localparam logic [7:0]  FLAG_WORD_OFFSET  = 8'h00;
    localparam logic [7:0]  CTRL_BASE_OFFSET  = 8'h40;

    // processor flag word layout
    localparam int          FLG_D_BIT         = 2;
    localparam int          FLG_I_BIT         = 6;
    localparam int          FLG_U_BIT         = 7;
    localparam int          FLG_IPL_LSB       = 12;
    localparam int          LEVEL_W           = 3;
    localparam logic [15:0] FLAG_WORD_RESET   = 16'h0000;
    localparam logic [15:0] FLAG_WRITE_MASK   = 16'h70ff;

    // per-source control register layout
    localparam int          CTRL_PRIO_LSB     = 0;
    localparam int          CTRL_PEND_BIT     = 3;
    localparam logic [2:0]  PRIO_RESET        = 3'h0;

    // sources and entry sequence
    localparam int          NUM_SOURCES       = 29;
    localparam int          PC_W              = 20;
    localparam int          NUM_W             = 6;
    localparam logic [5:0]  FIRST_PERIPH_NUM  = 6'h03;
    localparam logic [5:0]  USTACK_SWINT_LO   = 6'h20;
    localparam logic [5:0]  USTACK_SWINT_HI   = 6'h3f;
    localparam logic [19:0] INFO_ADDR         = 20'h00000;

    typedef enum logic [6:0]
    {
        SEQ_IDLE     = 7'h01,
        SEQ_INFO     = 7'h02,
        SEQ_SAVE     = 7'h04,
        SEQ_FLAGS    = 7'h08,
        SEQ_PUSH_FLG = 7'h10,
        SEQ_PUSH_PC  = 7'h20,
        SEQ_SET_IPL  = 7'h40
    } seq_state_t;

    typedef struct packed
    {
        logic        valid;
        logic        isPc;
        logic [19:0] data;
    } stack_push_t;

    typedef struct packed
    {
        logic        readStrobe;
        logic [19:0] addr;
    } info_fetch_t;

endpackage

// File: verilog/maskable_interrupt_acceptance.sv
// acceptance logic and entry sequence for maskable interrupts of the cpu core.
// assumes request pulses and sequencer strobes come from logic on ref_clk; register port
// strobes are one cycle long and never both high.
//
// How it works
// - global enable one admits, zero blocks all; software interrupt entries ignore it
// - global enable is cleared by reset
// - source request sets its pending bit
// - accepted request clears its pending bit
// - software zero clears pending, one ignored
// - accept needs enable, pending, level above threshold
// - three-bit level, zero disables the source
// - threshold n admits n+1 up, seven blocks
// - enable, pending, levels, threshold stored independently
// - concurrent requests survive control register rewrites
// - arbitrate at instruction end, enter next cycle
// - string and accumulate ops are suspended immediately
// - read info at address zero, then clear
// - flag word captured in hidden temporary register
// - entry clears enable, debug, stack select flags; software entries 32..63 keep stack select
// - push captured flags, then program counter
// - load accepted level into threshold, then vector
// - equal levels resolved by fixed hardware order
// - per-source control registers, enable/threshold in flags
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps

module maskable_interrupt_acceptance
    import irq_accept_pkg::*;
#(
    parameter int NSRC = NUM_SOURCES
)
(
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic [REG_ADDR_W-1:0] regAddr,
    input  wire logic [REG_DATA_W-1:0] regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output      logic [REG_DATA_W-1:0] regRdata,
    input  wire logic [NSRC-1:0]       reqPulse,
    input  wire logic                  instrDone,
    input  wire logic                  interruptibleOp,
    input  wire logic                  swIntReq,
    input  wire logic [NUM_W-1:0]      swIntNum,
    input  wire logic [PC_W-1:0]       pcValue,
    output      info_fetch_t           infoFetch,
    output      stack_push_t           stackPush,
    output      logic                  vectorFetch,
    output      logic [NUM_W-1:0]      vectorNum,
    output      logic                  suspendOp,
    output      logic                  seqBusy,
    output      logic [REG_DATA_W-1:0] processorFlagWord
);

    localparam int SRC_W = (NSRC > 1) ? $clog2(NSRC) : 1;

    typedef struct packed
    {
        logic             found;
        logic [SRC_W-1:0] idx;
        logic [2:0]       level;
    } arb_t;

    typedef struct packed
    {
        seq_state_t                  seq;
        logic [REG_DATA_W-1:0]       processor_flag_word;
        logic [REG_DATA_W-1:0]       tempFlg;
        logic [NSRC-1:0]             pend;
        logic [NSRC-1:0][LEVEL_W-1:0] prio;
        logic [SRC_W-1:0]            sel;
        logic [LEVEL_W-1:0]          selLevel;
        logic                        swEntry;
        logic [NUM_W-1:0]            num;
        logic [REG_DATA_W-1:0]       rdata;
        info_fetch_t                 info;
        stack_push_t                 push;
        logic                        vecStrobe;
        logic                        suspend;
    } state_t;

    state_t cur;
    state_t next_cur;
    arb_t   winner;

    // level zero never beats any threshold, and no level beats seven, so both
    // disable cases fall out of the strict compare with no extra logic
    function automatic logic outranks
    (
        input logic [LEVEL_W-1:0] level,
        input logic [LEVEL_W-1:0] cpu_priority_threshold,
        input logic               haveBest,
        input logic [LEVEL_W-1:0] bestLevel
    );
        return (level > cpu_priority_threshold) && (!haveBest || level >= bestLevel);
    endfunction

    function automatic arb_t arbitrate
    (
        input logic [NSRC-1:0]              pend,
        input logic [NSRC-1:0][LEVEL_W-1:0] prio,
        input logic [LEVEL_W-1:0]           cpu_priority_threshold
    );
        arb_t best;
        best = '0;
        // descending scan with >= lets the lowest index win a tie
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (pend[i] && outranks(prio[i], cpu_priority_threshold, best.found, best.level))
            begin
                best.found = 1'b1;
                best.idx   = SRC_W'(i);
                best.level = prio[i];
            end
        end
        return best;
    endfunction

    function automatic logic isCtrlAddr
    (
        input logic [REG_ADDR_W-1:0] addr
    );
        return (addr >= CTRL_BASE_OFFSET) && ({1'b0, addr - CTRL_BASE_OFFSET} < (REG_ADDR_W + 1)'(NSRC));
    endfunction

    function automatic logic [SRC_W-1:0] ctrlIndex
    (
        input logic [REG_ADDR_W-1:0] addr
    );
        logic [REG_ADDR_W-1:0] off;
        off = addr - CTRL_BASE_OFFSET;
        return off[SRC_W-1:0];
    endfunction

    // number reported for a peripheral source; software entries carry their own
    function automatic logic [NUM_W-1:0] periphNumber
    (
        input logic [SRC_W-1:0] idx
    );
        return FIRST_PERIPH_NUM + NUM_W'(idx);
    endfunction

    // only software entries numbered 32..63 keep the stack select flag
    function automatic logic keepsUserStack
    (
        input logic             swEntry,
        input logic [NUM_W-1:0] num
    );
        return swEntry && (num >= USTACK_SWINT_LO) && (num <= USTACK_SWINT_HI);
    endfunction

    // entry step three: enable and debug go low, stack select too unless kept
    function automatic logic [REG_DATA_W-1:0] entryFlags
    (
        input logic [REG_DATA_W-1:0] processor_flag_word,
        input logic                  keepU
    );
        logic [REG_DATA_W-1:0] res;
        res            = processor_flag_word;
        res[FLG_I_BIT] = 1'b0;
        res[FLG_D_BIT] = 1'b0;
        if (!keepU)
        begin
            res[FLG_U_BIT] = 1'b0;
        end
        return res;
    endfunction

    // control word as software reads it: level low, pending above, all else zero
    function automatic logic [REG_DATA_W-1:0] ctrlWord
    (
        input logic [LEVEL_W-1:0] level,
        input logic               pending
    );
        logic [REG_DATA_W-1:0] word;
        word                           = '0;
        word[CTRL_PRIO_LSB +: LEVEL_W] = level;
        word[CTRL_PEND_BIT]            = pending;
        return word;
    endfunction

    logic [LEVEL_W-1:0] curIpl;
    logic               curIFlag;
    logic               boundary;
    logic               flagHit;
    logic               ctrlHit;
    logic [SRC_W-1:0]   ctrlIdx;

    assign curIpl   = cur.processor_flag_word[FLG_IPL_LSB +: LEVEL_W];
    assign curIFlag = cur.processor_flag_word[FLG_I_BIT];
    assign winner   = arbitrate(cur.pend, cur.prio, curIpl);
    assign boundary = instrDone || interruptibleOp;
    assign flagHit  = (regAddr == FLAG_WORD_OFFSET);
    assign ctrlHit  = isCtrlAddr(regAddr);
    assign ctrlIdx  = ctrlIndex(regAddr);

    always_comb
    begin
        next_cur           = cur;
        next_cur.info      = '0;
        next_cur.push      = '0;
        next_cur.vecStrobe = 1'b0;
        next_cur.suspend   = 1'b0;

        // register writes; the sequence steps below are applied after and win on the flag word
        if (regWrite)
        begin
            if (flagHit)
            begin
                next_cur.processor_flag_word = regWdata & FLAG_WRITE_MASK;
            end
            else if (ctrlHit)
            begin
                next_cur.prio[ctrlIdx] = regWdata[CTRL_PRIO_LSB +: LEVEL_W];
                if (!regWdata[CTRL_PEND_BIT])
                begin
                    next_cur.pend[ctrlIdx] = 1'b0;
                end
            end
        end

        // one clocked read answer; unmapped addresses and the temporary register read zero
        next_cur.rdata = '0;
        if (regRead)
        begin
            if (flagHit)
            begin
                next_cur.rdata = cur.processor_flag_word;
            end
            else if (ctrlHit)
            begin
                next_cur.rdata = ctrlWord(cur.prio[ctrlIdx], cur.pend[ctrlIdx]);
            end
        end

        case (cur.seq)
            SEQ_IDLE:
            begin
                if (instrDone && swIntReq)
                begin
                    // software interrupt instructions ignore the enable flag and the levels
                    next_cur.seq     = SEQ_INFO;
                    next_cur.swEntry = 1'b1;
                    next_cur.num     = swIntNum;
                    next_cur.info.readStrobe = 1'b1;
                    next_cur.info.addr       = INFO_ADDR;
                end
                else if (boundary && curIFlag && winner.found)
                begin
                    next_cur.seq      = SEQ_INFO;
                    next_cur.swEntry  = 1'b0;
                    next_cur.sel      = winner.idx;
                    next_cur.selLevel = winner.level;
                    next_cur.num      = periphNumber(winner.idx);
                    next_cur.info.readStrobe = 1'b1;
                    next_cur.info.addr       = INFO_ADDR;
                    next_cur.suspend  = interruptibleOp && !instrDone;
                end
            end
            SEQ_INFO:
            begin
                // the clear follows the info read by one step
                if (!cur.swEntry)
                begin
                    next_cur.pend[cur.sel] = 1'b0;
                end
                next_cur.seq = SEQ_SAVE;
            end
            SEQ_SAVE:
            begin
                next_cur.tempFlg = next_cur.processor_flag_word;
                next_cur.seq     = SEQ_FLAGS;
            end
            SEQ_FLAGS:
            begin
                next_cur.processor_flag_word        = entryFlags(next_cur.processor_flag_word, keepsUserStack(cur.swEntry, cur.num));
                next_cur.push.valid = 1'b1;
                next_cur.push.isPc  = 1'b0;
                next_cur.push.data  = PC_W'(cur.tempFlg);
                next_cur.seq  = SEQ_PUSH_FLG;
            end
            SEQ_PUSH_FLG:
            begin
                next_cur.push.valid = 1'b1;
                next_cur.push.isPc  = 1'b1;
                next_cur.push.data  = pcValue;
                next_cur.seq  = SEQ_PUSH_PC;
            end
            SEQ_PUSH_PC:
            begin
                if (!cur.swEntry)
                begin
                    next_cur.processor_flag_word[FLG_IPL_LSB +: LEVEL_W] = cur.selLevel;
                end
                next_cur.seq = SEQ_SET_IPL;
            end
            SEQ_SET_IPL:
            begin
                next_cur.vecStrobe = 1'b1;
                next_cur.seq       = SEQ_IDLE;
            end
            default:
            begin
                next_cur.seq = SEQ_IDLE;
            end
        endcase

        // a request in the same cycle as any clear keeps its pending bit; this also covers
        // read-modify-write instructions that rewrite a control register
        next_cur.pend = next_cur.pend | reqPulse;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cur          <= '0;
            cur.seq      <= SEQ_IDLE;
            cur.processor_flag_word      <= FLAG_WORD_RESET;
            cur.prio     <= {NSRC{PRIO_RESET}};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign regRdata          = cur.rdata;
    assign infoFetch         = cur.info;
    assign stackPush         = cur.push;
    assign vectorFetch       = cur.vecStrobe;
    assign vectorNum         = cur.num;
    assign suspendOp         = cur.suspend;
    assign seqBusy           = (cur.seq != SEQ_IDLE);
    assign processorFlagWord = cur.processor_flag_word;

endmodule
